// [verilog/nos_defs.svh]
// nos_defs.svh: constants for the oscillator output stage
// assumes: included by bare name from design files under verilog/
`ifndef NOS_DEFS_SVH
`define NOS_DEFS_SVH

`define NOS_ACC_WIDTH 20
`define NOS_PWS_WIDTH 3
`define NOS_PULSE_CNT_WIDTH 8
`define NOS_RESET_ACC 20'h00000
`define NOS_RESET_OUT 1'b0

`endif

// [verilog/nos_pkg.sv]
// nos_pkg.sv: types shared by the oscillator output stage
// assumes: nothing beyond a SystemVerilog compiler
`default_nettype none
package nos_pkg;
    typedef enum logic [1:0] {
        NOS_IDLE,
        NOS_PULSE
    } nos_pulse_state_e;
endpackage
`default_nettype wire

// [verilog/nos_accumulator.sv]
// nos_accumulator.sv: phase accumulator giving a one-cycle overflow pulse
// assumes: single clock, asynchronous active-low reset
`timescale 1ns/10ps
`default_nettype none
`include "nos_defs.svh"
module nos_accumulator #(
    parameter int ACC_WIDTH = `NOS_ACC_WIDTH
) (
    // clock and reset
    input wire logic i_ref_clk,
    input wire logic i_arst_n,
    // control
    input wire logic i_enable,
    input wire logic [ACC_WIDTH-1:0] i_increment,
    // event
    output logic o_overflow
);
    logic [ACC_WIDTH-1:0] acc;
    logic [ACC_WIDTH:0] next_sum;

    // elaboration check: the carry logic needs at least two bits
    if (ACC_WIDTH < 2 || ACC_WIDTH > 32) begin : g_bad_width
        $error("nos_accumulator: ACC_WIDTH out of range");
    end

    assign next_sum = {1'b0, acc} + {1'b0, i_increment};

    // add every clock while enabled; carry out is the overflow event
    always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            acc <= '0;
            o_overflow <= 1'b0;
        end else if (i_enable) begin
            acc <= next_sum[ACC_WIDTH-1:0];
            o_overflow <= next_sum[ACC_WIDTH];
        end else begin
            o_overflow <= 1'b0;
        end
    end

    property p_ovf_one_cycle;
        @(posedge i_ref_clk) disable iff (!i_arst_n)
        (i_enable && next_sum[ACC_WIDTH]) |=> o_overflow;
    endproperty
    a_ovf_one_cycle: assert property (p_ovf_one_cycle) else $error("overflow missed");

    property p_ovf_needs_enable;
        @(posedge i_ref_clk) disable iff (!i_arst_n)
        !i_enable |=> !o_overflow;
    endproperty
    a_ovf_needs_enable: assert property (p_ovf_needs_enable) else $error("overflow while off");
endmodule // nos_accumulator
`default_nettype wire

// [verilog/nos_output_stage.sv]
// nos_output_stage.sv: oscillator output stage, modes, polarity, irq flag
// assumes: i_ref_clk is the oscillator's own clock, running also in sleep;
// all control inputs are synchronous to it; software clears the flag
`timescale 1ns/10ps
`default_nettype none
`include "nos_defs.svh"
module nos_output_stage #(
    parameter int ACC_WIDTH = `NOS_ACC_WIDTH,
    parameter int PWS_WIDTH = `NOS_PWS_WIDTH,
    parameter int CNT_WIDTH = `NOS_PULSE_CNT_WIDTH
) (
    // clock and reset
    input wire logic i_ref_clk,
    input wire logic i_arst_n,
    // control bits
    input wire logic i_osc_enable_bit,
    input wire logic i_pulse_freq_mode_sel,
    input wire logic i_output_polarity_bit,
    input wire logic [PWS_WIDTH-1:0] i_pulse_width_select,
    input wire logic [ACC_WIDTH-1:0] i_increment,
    input wire logic i_alt_pin_select,
    // interrupt control
    input wire logic i_overflow_irq_enable,
    input wire logic i_peripheral_irq_enable,
    input wire logic i_global_irq_enable,
    input wire logic i_overflow_irq_flag_clear,
    // status
    output logic o_output_value_bit,
    output logic o_overflow_irq_flag,
    output logic o_irq,
    output logic o_fast_osc_keep_alive,
    // output routing
    output logic o_config_logic_cell,
    output logic o_complementary_waveform_gen,
    output logic o_pin_primary,
    output logic o_pin_primary_oe,
    output logic o_pin_alternate,
    output logic o_pin_alternate_oe
);
    logic accumulator_overflow_event;
    logic raw_out;
    logic pol_out;
    logic pol_out_q;
    logic pol_q;
    logic [CNT_WIDTH-1:0] pulse_cnt;
    logic [CNT_WIDTH-1:0] pulse_len;
    nos_pkg::nos_pulse_state_e state;
    logic pol_edge_event;

    // elaboration check: the counter must hold two to the highest width code
    if (CNT_WIDTH < (1 << PWS_WIDTH) || PWS_WIDTH < 1 || PWS_WIDTH > 4) begin : g_bad_width
        $error("nos_output_stage: pulse counter too narrow for width field");
    end

    // length in periods, two to the n
    function automatic logic [CNT_WIDTH-1:0] width_periods(input logic [PWS_WIDTH-1:0] n);
        width_periods = CNT_WIDTH'(1) << n;
    endfunction

    assign pulse_len = width_periods(i_pulse_width_select);

    nos_accumulator #(
        .ACC_WIDTH(ACC_WIDTH)
    ) u_acc (
        .i_ref_clk(i_ref_clk),
        .i_arst_n(i_arst_n),
        .i_enable(i_osc_enable_bit),
        .i_increment(i_increment),
        .o_overflow(accumulator_overflow_event)
    );

    // raw (pre-polarity) output: toggle or pulse depending on mode
    always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            raw_out <= `NOS_RESET_OUT;
            state <= nos_pkg::NOS_IDLE;
            pulse_cnt <= '0;
        end else if (!i_osc_enable_bit) begin
            raw_out <= 1'b0;
            state <= nos_pkg::NOS_IDLE;
            pulse_cnt <= '0;
        end else if (!i_pulse_freq_mode_sel) begin
            // fixed-duty mode; 50% only while the increment holds still
            state <= nos_pkg::NOS_IDLE;
            pulse_cnt <= '0;
            if (accumulator_overflow_event) begin
                raw_out <= ~raw_out;
            end
        end else begin
            // pulse mode; a new overflow mid-pulse restarts it, the
            // output is undefined there anyway if software misconfigures
            case (state)
                nos_pkg::NOS_IDLE: begin
                    if (accumulator_overflow_event) begin
                        raw_out <= 1'b1;
                        pulse_cnt <= pulse_len - CNT_WIDTH'(1);
                        state <= nos_pkg::NOS_PULSE;
                    end else begin
                        raw_out <= 1'b0;
                    end
                end
                nos_pkg::NOS_PULSE: begin
                    if (accumulator_overflow_event) begin
                        raw_out <= 1'b1;
                        pulse_cnt <= pulse_len - CNT_WIDTH'(1);
                    end else if (pulse_cnt == '0) begin
                        raw_out <= 1'b0;
                        state <= nos_pkg::NOS_IDLE;
                    end else begin
                        pulse_cnt <= pulse_cnt - CNT_WIDTH'(1);
                    end
                end
                default: begin
                    raw_out <= 1'b0;
                    state <= nos_pkg::NOS_IDLE;
                end
            endcase
        end
    end

    // polarity is applied ahead of the output register, so the outputs follow it one clock later
    assign pol_out = raw_out ^ i_output_polarity_bit;

    // output value register shown to software and peripherals
    always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            pol_out_q <= 1'b0;
            pol_q <= 1'b0;
        end else begin
            pol_out_q <= pol_out;
            pol_q <= i_output_polarity_bit;
        end
    end

    assign o_output_value_bit = pol_out_q;
    assign o_config_logic_cell = pol_out_q;
    assign o_complementary_waveform_gen = pol_out_q;

    // pin relocation; only the selected pin is driven
    assign o_pin_primary = pol_out_q;
    assign o_pin_alternate = pol_out_q;
    assign o_pin_primary_oe = i_osc_enable_bit && !i_alt_pin_select;
    assign o_pin_alternate_oe = i_osc_enable_bit && i_alt_pin_select;

    // a polarity flip moves the output, so it counts as an irq event while the overflow, peripheral and global irq enables are all set
    assign pol_edge_event = (pol_q != i_output_polarity_bit) && i_overflow_irq_enable
        && i_peripheral_irq_enable && i_global_irq_enable;

    // sticky flag: a set in the same cycle as a clear wins
    always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_overflow_irq_flag <= 1'b0;
        end else if (accumulator_overflow_event || pol_edge_event) begin
            o_overflow_irq_flag <= 1'b1;
        end else if (i_overflow_irq_flag_clear) begin
            o_overflow_irq_flag <= 1'b0;
        end
    end

    assign o_irq = o_overflow_irq_flag && i_osc_enable_bit && i_overflow_irq_enable
        && i_peripheral_irq_enable && i_global_irq_enable;

    // keep the fast oscillator alive whenever the block is enabled
    assign o_fast_osc_keep_alive = i_osc_enable_bit;

    // checker helpers, not part of the output path: the length of the current
    // active run of the raw output, and the width latched when a pulse starts
    // cleanly; a restart or a mode change spoils the pulse, so only clean ones
    // are measured against the width field
    localparam int RUN_WIDTH = CNT_WIDTH + 1;
    logic [RUN_WIDTH-1:0] run_len;
    logic [CNT_WIDTH-1:0] started_len;
    logic pulse_clean;

    // run length saturates so a long fixed-duty high phase cannot wrap
    always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            run_len <= '0;
        end else if (!raw_out) begin
            run_len <= '0;
        end else if (run_len != '1) begin
            run_len <= run_len + RUN_WIDTH'(1);
        end
    end

    // a pulse counts as clean when it starts from idle with the output low;
    // leaving pulse mode or disabling the block drops the measurement
    always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            started_len <= '0;
            pulse_clean <= 1'h0;
        end else if (!i_osc_enable_bit || !i_pulse_freq_mode_sel) begin
            pulse_clean <= 1'h0;
        end else if (accumulator_overflow_event) begin
            started_len <= pulse_len;
            pulse_clean <= (state == nos_pkg::NOS_IDLE) && !raw_out;
        end
    end

    property p_fdc_toggle;
        @(posedge i_ref_clk) disable iff (!i_arst_n)
        (i_osc_enable_bit && !i_pulse_freq_mode_sel && accumulator_overflow_event)
            |=> (raw_out != $past(raw_out));
    endproperty
    a_fdc_toggle: assert property (p_fdc_toggle) else $error("no toggle on overflow");

    property p_pf_active;
        @(posedge i_ref_clk) disable iff (!i_arst_n)
        (i_osc_enable_bit && i_pulse_freq_mode_sel && accumulator_overflow_event) |=> raw_out;
    endproperty
    a_pf_active: assert property (p_pf_active) else $error("pulse not active");

    property p_pf_one_period;
        @(posedge i_ref_clk) disable iff (!i_arst_n)
        (i_osc_enable_bit && i_pulse_freq_mode_sel && i_pulse_width_select == '0
            && accumulator_overflow_event ##1 (i_osc_enable_bit && i_pulse_freq_mode_sel
            && !accumulator_overflow_event)) |=> !raw_out;
    endproperty
    a_pf_one_period: assert property (p_pf_one_period) else $error("pulse too long");

    property p_pf_width2;
        @(posedge i_ref_clk) disable iff (!i_arst_n)
        (i_osc_enable_bit && i_pulse_freq_mode_sel && i_pulse_width_select == 3'h1
            && accumulator_overflow_event ##1 (i_osc_enable_bit && i_pulse_freq_mode_sel
            && !accumulator_overflow_event)) |=> raw_out;
    endproperty
    a_pf_width2: assert property (p_pf_width2) else $error("pulse too short");

    property p_pol_out;
        @(posedge i_ref_clk) disable iff (!i_arst_n)
        1'b1 |=> o_output_value_bit == ($past(raw_out) ^ $past(i_output_polarity_bit));
    endproperty
    a_pol_out: assert property (p_pol_out) else $error("output value wrong");

    property p_flag_set;
        @(posedge i_ref_clk) disable iff (!i_arst_n)
        accumulator_overflow_event |=> o_overflow_irq_flag;
    endproperty
    a_flag_set: assert property (p_flag_set) else $error("flag not set");

    property p_pol_irq;
        @(posedge i_ref_clk) disable iff (!i_arst_n)
        pol_edge_event |=> o_overflow_irq_flag;
    endproperty
    a_pol_irq: assert property (p_pol_irq) else $error("polarity irq lost");

    property p_flag_sticky;
        @(posedge i_ref_clk) disable iff (!i_arst_n)
        (o_overflow_irq_flag && !i_overflow_irq_flag_clear) |=> o_overflow_irq_flag;
    endproperty
    a_flag_sticky: assert property (p_flag_sticky) else $error("flag self-cleared");

    property p_irq_gate;
        @(posedge i_ref_clk) disable iff (!i_arst_n)
        o_irq |-> (i_global_irq_enable && i_peripheral_irq_enable && i_overflow_irq_enable
            && i_osc_enable_bit && o_overflow_irq_flag);
    endproperty
    a_irq_gate: assert property (p_irq_gate) else $error("irq not gated");

    // further checks on the output path and the flag; all on the oscillator
    // clock, and every attempt is dropped while reset is low so that the
    // cleared registers never look like an event
    // mode behaviour between events
    property p_fdc_hold;
        @(posedge i_ref_clk) disable iff (!i_arst_n)
        (i_osc_enable_bit && !i_pulse_freq_mode_sel && !accumulator_overflow_event)
            |=> $stable(raw_out);
    endproperty
    a_fdc_hold: assert property (p_fdc_hold) else $error("toggle without overflow");

    property p_pf_idle_low;
        @(posedge i_ref_clk) disable iff (!i_arst_n)
        (i_osc_enable_bit && i_pulse_freq_mode_sel && state == nos_pkg::NOS_IDLE
            && !accumulator_overflow_event) |=> !raw_out;
    endproperty
    a_pf_idle_low: assert property (p_pf_idle_low) else $error("active while idle");

    property p_pf_width;
        @(posedge i_ref_clk) disable iff (!i_arst_n)
        (pulse_clean && state == nos_pkg::NOS_PULSE && pulse_cnt == '0 && i_osc_enable_bit
            && i_pulse_freq_mode_sel && !accumulator_overflow_event)
            |=> (run_len == {1'h0, started_len});
    endproperty
    a_pf_width: assert property (p_pf_width) else $error("pulse length wrong");

    property p_off_inactive;
        @(posedge i_ref_clk) disable iff (!i_arst_n)
        (!i_osc_enable_bit ##1 !i_osc_enable_bit)
            |=> (o_output_value_bit == $past(i_output_polarity_bit));
    endproperty
    a_off_inactive: assert property (p_off_inactive) else $error("idle level wrong");

    // flag and request
    property p_flag_clear;
        @(posedge i_ref_clk) disable iff (!i_arst_n)
        (i_overflow_irq_flag_clear && !accumulator_overflow_event && !pol_edge_event)
            |=> !o_overflow_irq_flag;
    endproperty
    a_flag_clear: assert property (p_flag_clear) else $error("flag clear lost");

    property p_flag_no_set;
        @(posedge i_ref_clk) disable iff (!i_arst_n)
        (!o_overflow_irq_flag && !accumulator_overflow_event && !pol_edge_event)
            |=> !o_overflow_irq_flag;
    endproperty
    a_flag_no_set: assert property (p_flag_no_set) else $error("flag set with no event");

    property p_irq_full;
        @(posedge i_ref_clk) disable iff (!i_arst_n)
        (o_overflow_irq_flag && i_osc_enable_bit && i_overflow_irq_enable
            && i_peripheral_irq_enable && i_global_irq_enable) |-> o_irq;
    endproperty
    a_irq_full: assert property (p_irq_full) else $error("irq not raised");

    // routing of the output value
    property p_routes;
        @(posedge i_ref_clk) disable iff (!i_arst_n)
        (o_config_logic_cell == o_output_value_bit)
            && (o_complementary_waveform_gen == o_output_value_bit);
    endproperty
    a_routes: assert property (p_routes) else $error("peripheral route differs");

    property p_pin_values;
        @(posedge i_ref_clk) disable iff (!i_arst_n)
        (o_pin_primary == o_output_value_bit) && (o_pin_alternate == o_output_value_bit);
    endproperty
    a_pin_values: assert property (p_pin_values) else $error("pin value differs");

    property p_pin_excl;
        @(posedge i_ref_clk) disable iff (!i_arst_n)
        o_pin_primary_oe |-> !o_pin_alternate_oe;
    endproperty
    a_pin_excl: assert property (p_pin_excl) else $error("both pin locations driven");

    c_fdc: cover property (@(posedge i_ref_clk) disable iff (!i_arst_n)
        !i_pulse_freq_mode_sel && accumulator_overflow_event);
    c_pf: cover property (@(posedge i_ref_clk) disable iff (!i_arst_n)
        state == nos_pkg::NOS_PULSE ##1 state == nos_pkg::NOS_IDLE);
    c_irq: cover property (@(posedge i_ref_clk) disable iff (!i_arst_n) o_irq);
    // the polarity event and a software clear are the other two flag paths
    c_pol_irq: cover property (@(posedge i_ref_clk) disable iff (!i_arst_n) pol_edge_event);
    c_flag_clear: cover property (@(posedge i_ref_clk) disable iff (!i_arst_n)
        o_overflow_irq_flag ##1 !o_overflow_irq_flag);
endmodule // nos_output_stage
`default_nettype wire

// [verification/nos_pin_sink.sv]
// nos_pin_sink.sv: pin net and the counters that watch the level on it
// assumes: pin outputs of the stage, one clock, the bench pulses i_clear
`timescale 1ns/10ps
`default_nettype none
module nos_pin_sink (
    // clock and control
    input wire logic i_ref_clk,
    input wire logic i_clear,
    // pins of the stage
    input wire logic i_pin_primary,
    input wire logic i_pin_primary_oe,
    input wire logic i_pin_alternate,
    input wire logic i_pin_alternate_oe,
    // observations
    output logic o_level,
    output logic [15:0] o_high_cycles,
    output logic [15:0] o_rises
);
    logic prev;
    // a board pull-down holds the net low while neither location drives it
    assign o_level = i_pin_primary_oe ? i_pin_primary :
        (i_pin_alternate_oe ? i_pin_alternate : 1'b0);
    // counts only cover whole windows, so the window must span full periods
    always @(posedge i_ref_clk) begin
        prev <= o_level;
        if (i_clear) begin
            o_high_cycles <= 16'h0000;
            o_rises <= 16'h0000;
        end else begin
            o_high_cycles <= o_high_cycles + {15'h0000, o_level};
            if (o_level && !prev) begin
                o_rises <= o_rises + 16'h0001;
            end
        end
    end
endmodule // nos_pin_sink
`default_nettype wire

// [verification/nos_output_stage_test.sv]
// nos_output_stage_test.sv: self-checking bench for the output stage
// assumes: design files under verilog/, pin model nos_pin_sink
`timescale 1ns/10ps
`default_nettype none
`include "nos_defs.svh"
module nos_output_stage_test;
    logic clk = 1'b0, arst_n, en, pfm, pol, alt, ie, pe, ge, fclr, sclr;
    logic [2:0] pws;
    logic [`NOS_ACC_WIDTH-1:0] inc;
    logic val, flag, irq, keep, config_logic_cell, complementary_waveform_gen, pp, ppoe, pa, paoe, level;
    logic [15:0] hi_cnt, rise_cnt;
    int fails = 0, num_checks = 0, cycles = 0;
    // 125 MHz clock
    always #4 clk = ~clk;
    nos_output_stage i_dut (.i_ref_clk(clk), .i_arst_n(arst_n), .i_osc_enable_bit(en),
        .i_pulse_freq_mode_sel(pfm), .i_output_polarity_bit(pol),
        .i_pulse_width_select(pws), .i_increment(inc), .i_alt_pin_select(alt),
        .i_overflow_irq_enable(ie), .i_peripheral_irq_enable(pe),
        .i_global_irq_enable(ge), .i_overflow_irq_flag_clear(fclr),
        .o_output_value_bit(val), .o_overflow_irq_flag(flag), .o_irq(irq),
        .o_fast_osc_keep_alive(keep), .o_config_logic_cell(config_logic_cell),
        .o_complementary_waveform_gen(complementary_waveform_gen), .o_pin_primary(pp),
        .o_pin_primary_oe(ppoe), .o_pin_alternate(pa), .o_pin_alternate_oe(paoe));
    nos_pin_sink i_sink (.i_ref_clk(clk), .i_clear(sclr), .i_pin_primary(pp),
        .i_pin_primary_oe(ppoe), .i_pin_alternate(pa), .i_pin_alternate_oe(paoe),
        .o_level(level), .o_high_cycles(hi_cnt), .o_rises(rise_cnt));
    task automatic test_done();
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    // a hang ends the run as a mismatch
    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            fails++;
            test_done();
        end
    end
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        num_checks++;
        if (g !== e) begin
            fails++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask
    // inputs change 1 ns after the edge, away from the sampling instant
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    // 64 cycles spans whole periods of every setting used below
    task automatic measure(input logic [15:0] hi, input logic [15:0] ri);
        sclr = 1'b1;
        tick(1);
        sclr = 1'b0;
        repeat (64) begin
            tick(1);
            chk("logic cell", val, config_logic_cell);
            chk("waveform gen", val, complementary_waveform_gen);
            chk("pin", val, level);
        end
        chk("high cycles", hi, hi_cnt);
        chk("rises", ri, rise_cnt);
    endtask
    initial begin
        {en, pfm, pol, alt, ie, pe, ge, fclr, sclr, arst_n} = 10'h000;
        pws = 3'h0;
        inc = 20'h00000;
        tick(20);
        arst_n = 1'b1;
        chk("value", 1'b0, val);
        chk("flag", 1'b0, flag);
        chk("irq", 1'b0, irq);
        // fixed duty: overflow every 4 cycles, period 8
        en = 1'b1;
        inc = 20'h40000;
        tick(20);
        chk("keep alive", 1'b1, keep);
        chk("primary oe", 1'b1, ppoe);
        chk("alternate oe", 1'b0, paoe);
        measure(16'h0020, 16'h0008);
        chk("flag", 1'b1, flag);
        // pulse mode: overflow every 16 cycles, every width shorter than that
        pfm = 1'b1;
        inc = 20'h10000;
        for (int n = 0; n < 4; n++) begin
            pws = n[2:0];
            tick(40);
            measure(16'(4 << n), 16'h0004);
        end
        // inverted polarity on the alternate pin
        pws = 3'h0;
        pol = 1'b1;
        alt = 1'b1;
        tick(40);
        chk("primary oe", 1'b0, ppoe);
        chk("alternate oe", 1'b1, paoe);
        measure(16'h003c, 16'h0004);
        // disabled stage stops and releases its pins
        en = 1'b0;
        pol = 1'b0;
        tick(4);
        chk("value", 1'b0, val);
        chk("pin", 1'b0, level);
        chk("keep alive", 1'b0, keep);
        // flag stays until cleared, irq needs all four enables
        pfm = 1'b0;
        inc = 20'h00000;
        tick(4);
        chk("flag", 1'b1, flag);
        for (int k = 0; k < 16; k++) begin
            {en, ie, pe, ge} = k[3:0];
            tick(2);
            chk("irq", 16'(k == 15), irq);
        end
        fclr = 1'b1;
        tick(1);
        fclr = 1'b0;
        tick(12);
        chk("flag", 1'b0, flag);
        chk("irq", 1'b0, irq);
        pol = 1'b1;
        tick(4);
        chk("flag", 1'b1, flag);
        chk("irq", 1'b1, irq);
        // second reset in mid-run; it clears the control bits as well, so no
        // polarity edge is seen when it ends
        arst_n = 1'b0;
        {en, pfm, pol, alt, ie, pe, ge} = 7'h00;
        tick(2);
        chk("flag", 1'b0, flag);
        chk("value", 1'b0, val);
        arst_n = 1'b1;
        tick(2);
        chk("flag", 1'h0, flag);
        chk("irq", 1'h0, irq);
        chk("value", 1'h0, val);
        test_done();
    end
endmodule // nos_output_stage_test
`default_nettype wire
